// ---- hdl/dbl_regs.svh ----
// timing counts, high-nibble bit positions and counter width for the two-byte converter load controller
`ifndef DBL_REGS_SVH
`define DBL_REGS_SVH
`define DBL_CLK_NS 10
`define DBL_SETUP_NS 50
`define DBL_SETUP_CYC ((`DBL_SETUP_NS + `DBL_CLK_NS - 1) / `DBL_CLK_NS)
`define DBL_STROBE_NS 40
`define DBL_STROBE_CYC ((`DBL_STROBE_NS + `DBL_CLK_NS - 1) / `DBL_CLK_NS)
`define DBL_HIGH_NIB_MSB 11
`define DBL_HIGH_NIB_LSB 8
`define DBL_CNT_W 8
`endif

// ---- hdl/dbl_pkg.sv ----
// types for the two-byte converter load controller
`default_nettype none
package dbl_pkg;
  typedef enum logic [2:0] {
    DBL_IDLE = 3'b000,
    DBL_HIGH = 3'b001,
    DBL_LOW = 3'b010,
    DBL_ADDR = 3'b011,
    DBL_LOAD = 3'b100,
    DBL_DONE = 3'b101
  } dbl_state_e;
endpackage : dbl_pkg
`default_nettype wire

// ---- hdl/dbl_strobe_decode.sv ----
// registered decoder steering the active-low load strobe to one converter
`timescale 1ns/1ns
`default_nettype none
module dbl_strobe_decode #(
  parameter int unsigned NUM_CONV = 2,
  parameter int unsigned SEL_W = 1
) (
  input wire logic i_clk,
  input wire logic i_rst_n,
  input wire logic i_enable,
  input wire logic [SEL_W-1:0] i_sel,
  output logic [NUM_CONV-1:0] o_load_n
);
  // one strobe per converter, only the addressed one goes low
  genvar g;
  generate
    for (g = 0; g < NUM_CONV; g++) begin : g_dec
      always_ff @(posedge i_clk) begin
        if (!i_rst_n) begin
          o_load_n[g] <= 1'b1;
        end else begin
          o_load_n[g] <= !(i_enable && (i_sel == SEL_W'(g)));
        end
      end
    end
  endgenerate
endmodule : dbl_strobe_decode
`default_nettype wire

// ---- hdl/dbl_load_ctrl.sv ----
// host controller loading 12-bit codes into converters as two bytes
// Notes on behaviour
// - shared data, strobe only the chosen converter
// - decoder stays disabled while select changes
// - send high byte first, then low byte
// - byte select high passes high byte
// - high byte low nibble feeds top bits
// - byte select low holds high, passes low
// - low byte drives data bits seven to zero
// - pulse load low then high after bytes
// - high byte upper nibble is zero
// - limit codes loaded one converter at time
`timescale 1ns/1ns
`default_nettype none
`include "dbl_regs.svh"
module dbl_load_ctrl
  import dbl_pkg::*;
#(
  parameter int unsigned NUM_CONV = 2,
  parameter int unsigned SEL_W = 1
) (
  input wire logic i_clk,
  input wire logic i_rst_n,
  input wire logic i_start,
  input wire logic [11:0] i_code,
  input wire logic [SEL_W-1:0] i_limit_converter_select,
  input wire logic i_clear,
  input wire logic i_window_ok,
  output logic o_busy,
  output logic o_done,
  output logic o_in_window,
  output logic [7:0] o_data,
  output logic o_byte_select,
  output logic o_output_clear_n,
  output logic [NUM_CONV-1:0] o_load_n
);
  localparam logic [`DBL_CNT_W-1:0] SETUP_CYC = `DBL_CNT_W'(`DBL_SETUP_CYC);
  localparam logic [`DBL_CNT_W-1:0] STROBE_CYC = `DBL_CNT_W'(`DBL_STROBE_CYC);

  dbl_state_e state_reg;
  logic [`DBL_CNT_W-1:0] cnt_reg;
  logic [11:0] code_reg;
  logic [SEL_W-1:0] sel_reg;
  logic dec_en_reg;
  logic [2:0] win_sync_reg;
  wire cnt_zero = (cnt_reg == '0);

  // sequencer: high byte, low byte, settle address, strobe
  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      state_reg <= DBL_IDLE;
    end else begin
      case (state_reg)
        DBL_IDLE: if (i_start && !i_clear) state_reg <= DBL_HIGH;
        DBL_HIGH: if (cnt_zero) state_reg <= DBL_LOW;
        DBL_LOW: if (cnt_zero) state_reg <= DBL_ADDR;
        DBL_ADDR: if (cnt_zero) state_reg <= DBL_LOAD;
        DBL_LOAD: if (cnt_zero) state_reg <= DBL_DONE;
        DBL_DONE: state_reg <= DBL_IDLE;
        default: state_reg <= DBL_IDLE;
      endcase
    end
  end

  // dwell counter for each phase
  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      cnt_reg <= '0;
    end else if (state_reg == DBL_IDLE || cnt_zero) begin
      // load phase gets one spare cycle so the strobe is low a full STROBE_CYC
      cnt_reg <= (state_reg == DBL_ADDR) ? STROBE_CYC : SETUP_CYC - 1'b1;
    end else begin
      cnt_reg <= cnt_reg - 1'b1;
    end
  end

  // capture code and target converter at start
  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      code_reg <= '0;
      sel_reg <= '0;
    end else if (state_reg == DBL_IDLE && i_start) begin
      code_reg <= i_code;
      sel_reg <= i_limit_converter_select;
    end
  end

  // byte lanes and byte select
  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      o_data <= 8'h00;
      o_byte_select <= 1'b0;
    end else begin
      case (state_reg)
        DBL_HIGH: begin
          o_data <= {4'h0, code_reg[`DBL_HIGH_NIB_MSB:`DBL_HIGH_NIB_LSB]};
          o_byte_select <= 1'b1;
        end
        DBL_LOW: begin
          // select drops first, lane changes a cycle later so the high latch holds
          o_data <= o_byte_select ? o_data : code_reg[7:0];
          o_byte_select <= 1'b0;
        end
        default: o_byte_select <= 1'b0;
      endcase
    end
  end

  // decoder enabled only after address settled
  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      dec_en_reg <= 1'b0;
    end else begin
      dec_en_reg <= (state_reg == DBL_LOAD) && !cnt_zero;
    end
  end

  dbl_strobe_decode #(
    .NUM_CONV(NUM_CONV),
    .SEL_W(SEL_W)
  ) u_dec (
    .i_clk(i_clk),
    .i_rst_n(i_rst_n),
    .i_enable(dec_en_reg),
    .i_sel(sel_reg),
    .o_load_n(o_load_n)
  );

  // clear pin, held high from reset
  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      o_output_clear_n <= 1'b1;
    end else begin
      o_output_clear_n <= !i_clear;
    end
  end

  // status flags
  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      o_busy <= 1'b0;
      o_done <= 1'b0;
    end else begin
      o_busy <= (state_reg != DBL_IDLE) || (i_start && !i_clear);
      o_done <= (state_reg == DBL_DONE);
    end
  end

  // window result pin synchroniser, low means outside limits
  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      win_sync_reg <= 3'b111;
      o_in_window <= 1'b1;
    end else begin
      win_sync_reg <= {win_sync_reg[1:0], i_window_ok};
      if (win_sync_reg[2] == win_sync_reg[1]) o_in_window <= win_sync_reg[1];
    end
  end

  // checks: strobe shape and steering
  a_sel_stable: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    !(&o_load_n) |-> $stable(sel_reg))
    else $error("select changed during strobe");
  a_one_strobe: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    $countones(~o_load_n) <= 1)
    else $error("more than one strobe low");
  a_strobe_bsel: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    !(&o_load_n) |-> !o_byte_select && o_data == code_reg[7:0])
    else $error("strobe without both bytes in place");
  a_strobe_width: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    $fell(&o_load_n) |-> (!(&o_load_n)) [*4] ##1 (&o_load_n))
    else $error("strobe pulse not four cycles long");
  a_strobe_ends: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    $fell(&o_load_n) |-> ##[1:20] (&o_load_n))
    else $error("strobe never released");
  a_done_after: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    o_done |-> (&o_load_n))
    else $error("done while a strobe is low");
  a_addr_quiet: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    state_reg == DBL_ADDR |-> (&o_load_n) && !dec_en_reg)
    else $error("decoder active while address settles");
  // checks: byte order and lanes
  a_high_nibble: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    o_byte_select |-> o_data[7:4] == 4'h0)
    else $error("high byte upper nibble not zero");
  a_high_first: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    $rose(o_byte_select) |-> o_data == {4'h0, code_reg[11:8]})
    else $error("wrong high byte");
  a_hold_high: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    $fell(o_byte_select) |-> o_data == {4'h0, code_reg[11:8]})
    else $error("high byte changed as its latch closed");
  a_low_after: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    $fell(o_byte_select) |=> o_data == code_reg[7:0])
    else $error("wrong low byte");
  a_start_seq: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    state_reg == DBL_IDLE && i_start && !i_clear |=> ##[1:2] o_byte_select)
    else $error("high byte not sent first");
  // checks: clear, reset and window pins
  a_clear_follow: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    i_clear |=> !o_output_clear_n)
    else $error("clear not driven");
  a_clear_release: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    !i_clear |=> o_output_clear_n)
    else $error("clear held without request");
  a_init_idle: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    $rose(i_rst_n) |-> o_output_clear_n && (&o_load_n) && !o_byte_select)
    else $error("pins not idle after reset");
  a_window_sync: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    win_sync_reg[2] == win_sync_reg[1] |=> o_in_window == $past(win_sync_reg[1]))
    else $error("window result not taken from agreeing flops");
  // scenario covers
  c_load: cover property (@(posedge i_clk) disable iff (!i_rst_n) $fell(&o_load_n));
  c_done: cover property (@(posedge i_clk) disable iff (!i_rst_n) o_done);
  c_clear: cover property (@(posedge i_clk) disable iff (!i_rst_n) !o_output_clear_n);
  c_high_byte: cover property (@(posedge i_clk) disable iff (!i_rst_n) $rose(o_byte_select));
endmodule : dbl_load_ctrl
`default_nettype wire

// ---- sim/dbl_conv_model.sv ----
// behavioural pair of converters with byte latches and window result
`timescale 1ns/1ns
`default_nettype none
module dbl_conv_model #(
  parameter int unsigned NUM_CONV = 2
) (
  input wire logic [7:0] i_data,
  input wire logic i_byte_select,
  input wire logic i_output_clear_n,
  input wire logic [NUM_CONV-1:0] i_load_n,
  input wire logic [11:0] i_test,
  output logic o_window_ok,
  output logic [11:0] o_conv [NUM_CONV]
);
  logic [3:0] high_byte_latch;
  logic [7:0] low_byte_latch;
  // transparent latches steered by byte select
  always @* begin
    if (i_byte_select) high_byte_latch = i_data[3:0];
    else low_byte_latch = i_data;
  end
  // clear wins, strobe low copies latches, otherwise hold
  always @* begin
    for (int i = 0; i < NUM_CONV; i++) begin
      if (!i_output_clear_n) o_conv[i] = 12'h000;
      else if (!i_load_n[i]) o_conv[i] = {high_byte_latch, low_byte_latch};
    end
  end
  // low when the test value leaves the window
  assign o_window_ok = (i_test <= o_conv[0]) && (i_test >= o_conv[1]);
endmodule : dbl_conv_model
`default_nettype wire

// ---- sim/dbl_load_ctrl_tb_top.sv ----
// self-checking bench for the two-byte converter load controller
`timescale 1ns/1ns
`default_nettype none
module dbl_load_ctrl_tb_top;
  logic i_clk = 0, i_rst_n = 0, i_start = 0, i_sel = 0, i_clear = 0;
  logic window_ok, o_busy, o_done, o_in_window, o_byte_select, o_output_clear_n;
  logic [11:0] i_code = 0, test = 0, exp_conv [2], conv [2];
  logic [7:0] o_data;
  logic [1:0] o_load_n;
  logic [12:0] note;
  logic exp_win;
  logic [12:0] q[$];
  int n_fail = 0, compares = 0, seed = 32'h99d5;
  // free-running clock
  always #5 i_clk = ~i_clk;
  dbl_load_ctrl u_dbl_load_ctrl (.i_clk(i_clk), .i_rst_n(i_rst_n), .i_start(i_start),
    .i_code(i_code), .i_limit_converter_select(i_sel), .i_clear(i_clear),
    .i_window_ok(window_ok), .o_busy(o_busy), .o_done(o_done), .o_in_window(o_in_window),
    .o_data(o_data), .o_byte_select(o_byte_select), .o_output_clear_n(o_output_clear_n),
    .o_load_n(o_load_n));
  dbl_conv_model u_dbl_conv_model (.i_data(o_data), .i_byte_select(o_byte_select),
    .i_output_clear_n(o_output_clear_n), .i_load_n(o_load_n), .i_test(test),
    .o_window_ok(window_ok), .o_conv(conv));
  task automatic check(input logic [11:0] got, input logic [11:0] exp, input string what);
    compares++;
    if (got !== exp) begin
      n_fail++;
      $display("unexpected %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask : check
  task automatic close_out;
    $display("counts: %0d mismatches in %0d compares", n_fail, compares);
    if (n_fail == 0 && compares > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask : close_out
  // one load, noting the expected converter contents
  task automatic load(input logic [11:0] code, input logic sel);
    @(posedge i_clk);
    i_code <= code;
    i_sel <= sel;
    i_start <= 1'b1;
    q.push_back({sel, code});
    @(posedge i_clk);
    i_start <= 1'b0;
    for (int k = 0; k < 40 && o_done !== 1'b1; k++) @(posedge i_clk);
  endtask : load
  // oldest note against both converters at each done pulse
  always @(posedge i_clk) begin
    if (o_done === 1'b1 && q.size() > 0) begin
      note = q.pop_front();
      exp_conv[note[12]] = note[11:0];
      check(conv[0], exp_conv[0], "conv0");
      check(conv[1], exp_conv[1], "conv1");
    end
  end
  // main sequence: reset, refused start under clear, then loads
  initial begin
    repeat (8) @(posedge i_clk);
    i_rst_n <= 1'b1;
    @(posedge i_clk);
    check({8'h00, o_byte_select, o_output_clear_n, o_load_n}, 12'h007, "idle pins");
    i_clear <= 1'b1;
    i_start <= 1'b1;
    repeat (4) @(posedge i_clk);
    i_clear <= 1'b0;
    i_start <= 1'b0;
    check(conv[0] | conv[1], 12'h000, "clear");
    check({11'h000, o_busy}, 12'h000, "refused start");
    exp_conv[0] = 12'h000;
    exp_conv[1] = 12'h000;
    for (int i = 0; i < 12; i++) begin
      load(i < 2 ? {12{i[0]}} : 12'($random(seed)), i[0]);
      test <= 12'($random(seed));
      repeat (6) @(posedge i_clk);
      exp_win = (test <= exp_conv[0]) && (test >= exp_conv[1]);
      check({11'h000, o_in_window}, {11'h000, exp_win}, "window");
    end
    check(12'(q.size()), 12'h000, "pending notes");
    close_out();
  end
  // watchdog against a hang
  initial begin
    #20000;
    n_fail++;
    $display("unexpected %0t timeout", $time);
    close_out();
  end
endmodule : dbl_load_ctrl_tb_top
`default_nettype wire
